//--- rtl/smai_pkg.sv
package smai_pkg;

    // Address frame
    localparam int ADDR_BITS = 3;
    localparam int FRAME_IN_BITS = 4;

    // Sampling window: 4.5 serial periods, counted as serial clock edges of either kind
    localparam int SAMPLE_EDGES = 9;

    // Conversion length in conversion clock periods
    localparam int CONV_PERIODS = 41;

    // Result and output framing
    localparam int RESULT_BITS = 10;
    localparam int PAD_BITS = 6;
    localparam int SR_BITS = 16;
    localparam logic [4:0] LEN_LEFT = 5'h0a;
    localparam logic [4:0] LEN_RIGHT = 5'h10;

    // Buffer shape
    localparam int FIFO_DEPTH = 16;

    // Reset values and first approximation trial
    localparam logic [RESULT_BITS-1:0] RESULT_RST = 10'h000;
    localparam logic [SR_BITS-1:0] SR_RST = 16'h0000;
    localparam logic [RESULT_BITS-1:0] SAR_FIRST_TRIAL = 10'h200;

    typedef struct packed {
        logic right_just;
        logic [RESULT_BITS-1:0] code;
    } smai_result_s;

    localparam int RESULT_W = $bits(smai_result_s);

    typedef enum logic [2:0] {
        ST_ADDR,
        ST_SAMPLE,
        ST_CONV,
        ST_PUSH,
        ST_LOAD
    } smai_state_e;

endpackage : smai_pkg

//--- rtl/smai_fifo.sv
`timescale 1ns/1ns
module smai_fifo #(
    parameter int WIDTH = 11,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // Fill side
    input wire logic in_valid_in,
    input wire logic [WIDTH-1:0] in_data_in,
    output logic in_ready_out,
    // Drain side
    output logic out_valid_out,
    output logic [WIDTH-1:0] out_data_out,
    input wire logic out_ready_in
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr_r;
    logic [AW-1:0] rd_ptr_r;
    logic [AW:0] count_r;
    logic push;
    logic pop;

    assign in_ready_out = (count_r != (AW+1)'(DEPTH));
    assign out_valid_out = (count_r != '0);
    assign out_data_out = mem[rd_ptr_r];
    assign push = in_valid_in && in_ready_out;
    assign pop = out_valid_out && out_ready_in;

    // Storage
    always_ff @(posedge clk_in) begin
        if (push) begin
            mem[wr_ptr_r] <= in_data_in;
        end
    end

    // Pointers and fill level
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r <= '0;
        end else begin
            if (push) begin
                wr_ptr_r <= (wr_ptr_r == AW'(DEPTH - 1)) ? '0 : wr_ptr_r + 1'b1;
            end
            if (pop) begin
                rd_ptr_r <= (rd_ptr_r == AW'(DEPTH - 1)) ? '0 : rd_ptr_r + 1'b1;
            end
            if (push && !pop) begin
                count_r <= count_r + 1'b1;
            end else if (pop && !push) begin
                count_r <= count_r - 1'b1;
            end
        end
    end

endmodule : smai_fifo

//--- rtl/smai_core.sv
`timescale 1ns/1ns
module smai_core (
    // Clock and reset
    input wire logic core_clk_in,
    input wire logic sys_rst_in,
    // Serial link pins
    input wire logic serial_clk_in,
    input wire logic conversion_clock_in,
    input wire logic chip_sel_n_in,
    input wire logic out_en_n_in,
    input wire logic serial_input_in,
    output logic serial_output_out,
    output logic serial_output_oe_out,
    output logic conversion_busy_out,
    // Analog front end
    input wire logic comparator_in,
    output logic [smai_pkg::ADDR_BITS-1:0] input_selector_out,
    output logic sample_en_out,
    output logic [smai_pkg::RESULT_BITS-1:0] approximation_register_out
);
    localparam int NSYNC = 6;

    logic [NSYNC-1:0] meta_r;
    logic [NSYNC-1:0] sync_r;
    logic sclk_prev_r;
    logic conversion_clock_prev_r;
    logic sclk_rise;
    logic sclk_fall;
    logic conversion_clock_rise;
    logic cs_low;
    logic oe_low;
    logic din_s;
    logic cmp_s;

    smai_pkg::smai_state_e state_r;
    logic [2:0] in_count_r;
    logic [smai_pkg::ADDR_BITS-1:0] addr_sr_r;
    logic right_just_r;
    logic [3:0] sample_cnt_r;
    logic [5:0] conv_cnt_r;
    logic [smai_pkg::RESULT_BITS-1:0] sar_r;
    logic [smai_pkg::RESULT_BITS-1:0] trial_bit_r;
    logic busy_r;

    logic [smai_pkg::SR_BITS-1:0] out_sr_r;
    logic [4:0] out_len_r;
    logic [4:0] out_cnt_r;

    logic fifo_in_valid;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic fifo_out_ready;
    smai_pkg::smai_result_s fifo_in_data;
    smai_pkg::smai_result_s fifo_out_data;
    logic load_now;
    logic mid_exchange;

    // Frame length in serial periods for a given format
    function automatic logic [4:0] frame_len(input logic rj);
        frame_len = rj ? smai_pkg::LEN_RIGHT : smai_pkg::LEN_LEFT;
    endfunction : frame_len

    // Output word layout for a given format
    function automatic logic [smai_pkg::SR_BITS-1:0] frame_word(input smai_pkg::smai_result_s r);
        if (r.right_just) begin
            frame_word = {{smai_pkg::PAD_BITS{1'b0}}, r.code};
        end else begin
            frame_word = {r.code, {smai_pkg::PAD_BITS{1'b0}}};
        end
    endfunction : frame_word

    // Two-stage synchronisers for every pin from outside this clock
    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            meta_r <= 6'h0c;
            sync_r <= 6'h0c;
        end else begin
            meta_r <= {comparator_in, serial_input_in, out_en_n_in, chip_sel_n_in,
                       conversion_clock_in, serial_clk_in};
            sync_r <= meta_r;
        end
    end

    // Edge history of the sampled clocks
    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            sclk_prev_r <= 1'b0;
            conversion_clock_prev_r <= 1'b0;
        end else begin
            sclk_prev_r <= sync_r[0];
            conversion_clock_prev_r <= sync_r[1];
        end
    end

    assign sclk_rise = sync_r[0] && !sclk_prev_r;
    assign sclk_fall = !sync_r[0] && sclk_prev_r;
    assign conversion_clock_rise = sync_r[1] && !conversion_clock_prev_r;
    assign cs_low = !sync_r[2];
    assign oe_low = !sync_r[3];
    assign din_s = sync_r[4];
    assign cmp_s = sync_r[5];

    // Sequencer: address, sampling, conversion, hand-off
    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            state_r <= smai_pkg::ST_ADDR;
            in_count_r <= 3'h0;
            addr_sr_r <= '0;
            right_just_r <= 1'b0;
            sample_cnt_r <= 4'h0;
            conv_cnt_r <= 6'h00;
        end else begin
            case (state_r)
                smai_pkg::ST_ADDR: begin
                    if (sclk_rise && cs_low) begin
                        if (in_count_r < 3'(smai_pkg::ADDR_BITS)) begin
                            addr_sr_r <= {addr_sr_r[smai_pkg::ADDR_BITS-2:0], din_s};
                            in_count_r <= in_count_r + 3'h1;
                        end else begin
                            right_just_r <= din_s;
                            in_count_r <= 3'h0;
                            sample_cnt_r <= 4'h0;
                            state_r <= smai_pkg::ST_SAMPLE;
                        end
                    end
                end
                smai_pkg::ST_SAMPLE: begin
                    if (sclk_rise || sclk_fall) begin
                        if (sample_cnt_r == 4'(smai_pkg::SAMPLE_EDGES - 1)) begin
                            conv_cnt_r <= 6'h00;
                            state_r <= smai_pkg::ST_CONV;
                        end else begin
                            sample_cnt_r <= sample_cnt_r + 4'h1;
                        end
                    end
                end
                smai_pkg::ST_CONV: begin
                    if (conversion_clock_rise) begin
                        if (conv_cnt_r == 6'(smai_pkg::CONV_PERIODS - 1)) begin
                            state_r <= smai_pkg::ST_PUSH;
                        end else begin
                            conv_cnt_r <= conv_cnt_r + 6'h01;
                        end
                    end
                end
                smai_pkg::ST_PUSH: begin
                    if (fifo_in_ready) begin
                        state_r <= smai_pkg::ST_LOAD;
                    end
                end
                smai_pkg::ST_LOAD: begin
                    if (load_now) begin
                        state_r <= smai_pkg::ST_ADDR;
                    end
                end
                default: begin
                    state_r <= smai_pkg::ST_ADDR;
                end
            endcase
        end
    end

    // Successive approximation, one bit per conversion clock rising edge
    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            sar_r <= smai_pkg::RESULT_RST;
            trial_bit_r <= '0;
        end else if (state_r == smai_pkg::ST_SAMPLE) begin
            sar_r <= smai_pkg::SAR_FIRST_TRIAL;
            trial_bit_r <= smai_pkg::SAR_FIRST_TRIAL;
        end else if (state_r == smai_pkg::ST_CONV && conversion_clock_rise && trial_bit_r != '0) begin
            sar_r <= (cmp_s ? sar_r : (sar_r & ~trial_bit_r)) | (trial_bit_r >> 1);
            trial_bit_r <= trial_bit_r >> 1;
        end
    end

    // Busy flag: up for the whole approximation, down once the result is loaded
    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            busy_r <= 1'b0;
        end else if (state_r == smai_pkg::ST_SAMPLE && (sclk_rise || sclk_fall)
                     && sample_cnt_r == 4'(smai_pkg::SAMPLE_EDGES - 1)) begin
            busy_r <= 1'b1;
        end else if (load_now) begin
            busy_r <= 1'b0;
        end
    end

    // Result buffer between converter and output shifter
    assign fifo_in_valid = (state_r == smai_pkg::ST_PUSH);
    assign fifo_in_data = '{right_just: right_just_r, code: sar_r};
    assign fifo_out_ready = (state_r == smai_pkg::ST_LOAD);
    assign load_now = fifo_out_valid && fifo_out_ready;

    smai_fifo #(
        .WIDTH(smai_pkg::RESULT_W),
        .DEPTH(smai_pkg::FIFO_DEPTH)
    ) u_fifo (
        .clk_in(core_clk_in),
        .rst_in(sys_rst_in),
        .in_valid_in(fifo_in_valid),
        .in_data_in(fifo_in_data),
        .in_ready_out(fifo_in_ready),
        .out_valid_out(fifo_out_valid),
        .out_data_out(fifo_out_data),
        .out_ready_in(fifo_out_ready)
    );

    assign mid_exchange = (out_cnt_r != 5'h00) && (out_cnt_r < out_len_r);

    // Output shift register
    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            out_sr_r <= smai_pkg::SR_RST;
            out_len_r <= smai_pkg::LEN_LEFT;
            out_cnt_r <= 5'h00;
        end else if (load_now) begin
            out_cnt_r <= 5'h00;
            out_len_r <= frame_len(fifo_out_data.right_just);
            if (mid_exchange) begin
                out_sr_r <= smai_pkg::SR_RST;
            end else begin
                out_sr_r <= frame_word(fifo_out_data);
            end
        end else if (sclk_fall && cs_low && oe_low) begin
            out_sr_r <= {out_sr_r[smai_pkg::SR_BITS-2:0], 1'b0};
            if (out_cnt_r != 5'h1f) begin
                out_cnt_r <= out_cnt_r + 5'h01;
            end
        end
    end

    // Registered pins
    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            serial_output_out <= 1'b0;
            serial_output_oe_out <= 1'b0;
            conversion_busy_out <= 1'b0;
            input_selector_out <= '0;
            sample_en_out <= 1'b0;
            approximation_register_out <= smai_pkg::RESULT_RST;
        end else begin
            serial_output_out <= out_sr_r[smai_pkg::SR_BITS-1];
            serial_output_oe_out <= cs_low && oe_low;
            conversion_busy_out <= busy_r;
            input_selector_out <= addr_sr_r;
            sample_en_out <= (state_r == smai_pkg::ST_SAMPLE);
            approximation_register_out <= sar_r;
        end
    end

endmodule : smai_core

//--- sim/smai_core_properties.sv
`timescale 1ns/1ns
module smai_core_properties (
    // Clock and reset
    input wire logic core_clk_in,
    input wire logic sys_rst_in,
    // Link pins
    input wire logic serial_clk_in,
    input wire logic conversion_clock_in,
    input wire logic chip_sel_n_in,
    input wire logic out_en_n_in,
    input wire logic serial_output_out,
    input wire logic serial_output_oe_out,
    input wire logic conversion_busy_out,
    // Front end
    input wire logic [smai_pkg::ADDR_BITS-1:0] input_selector_out,
    input wire logic sample_en_out
);
    logic [3:0] up_r;
    logic [4:0] edges_r;
    logic [5:0] conversion_clock_r;
    logic [7:0] fall_r;
    logic [3:0] sclk_h_r;
    // Settle time after reset
    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            up_r <= 4'h0;
        end else if (!up_r[3]) begin
            up_r <= up_r + 4'h1;
        end
    end
    // Serial pin history, aligned with the core's synchroniser and output delay
    always_ff @(posedge core_clk_in) begin
        sclk_h_r <= {sclk_h_r[2:0], serial_clk_in};
    end
    // Serial edges inside the sampling window
    always_ff @(posedge core_clk_in) begin
        if (!sample_en_out) begin
            edges_r <= 5'h00;
        end else if (sclk_h_r[3] != sclk_h_r[2]) begin
            edges_r <= edges_r + 5'h01;
        end
    end
    // Conversion clock rises while busy
    always_ff @(posedge core_clk_in) begin
        if (!conversion_busy_out) begin
            conversion_clock_r <= 6'h00;
        end else if ($past(conversion_busy_out) && $past(conversion_clock_in, 4)
                     && !$past(conversion_clock_in, 5)) begin
            conversion_clock_r <= conversion_clock_r + 6'h01;
        end
    end
    // Recent serial falling edges
    always_ff @(posedge core_clk_in) begin
        fall_r <= {fall_r[6:0], $fell(serial_clk_in)};
    end
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (sys_rst_in || !up_r[3]);
    AST_OE_ON: assert property ((!chip_sel_n_in && !out_en_n_in) [*5] |-> serial_output_oe_out)
        else $error("output not driven while enabled");
    AST_OE_OFF: assert property ((chip_sel_n_in || out_en_n_in) [*5] |-> !serial_output_oe_out)
        else $error("output driven while disabled");
    AST_SEL_HOLD: assert property (chip_sel_n_in [*6] |-> $stable(input_selector_out))
        else $error("selector moved while deselected");
    AST_SEL_IDLE: assert property ($changed(input_selector_out) |-> !conversion_busy_out)
        else $error("selector moved during conversion");
    AST_SAMPLE_EDGES: assert property ($fell(sample_en_out) |-> edges_r == 5'(smai_pkg::SAMPLE_EDGES))
        else $error("sampling window length wrong");
    AST_NO_OVERLAP: assert property (!(sample_en_out && conversion_busy_out))
        else $error("sampling during conversion");
    AST_BUSY_START: assert property ($rose(conversion_busy_out) |-> $past(sample_en_out) || $past(sample_en_out, 2))
        else $error("busy rose without sampling");
    AST_BUSY_LEN: assert property ($fell(conversion_busy_out) |-> conversion_clock_r == 6'(smai_pkg::CONV_PERIODS))
        else $error("busy length wrong");
    AST_OUT_CAUSE: assert property ($changed(serial_output_out) |->
        (|fall_r[5:1]) || $fell(conversion_busy_out) || $changed(serial_output_oe_out))
        else $error("output changed without cause");
    COV_LOAD: cover property ($fell(conversion_busy_out) && !chip_sel_n_in);
    COV_SAMPLE: cover property ($rose(sample_en_out));
    COV_IGNORED: cover property (chip_sel_n_in [*6] ##1 serial_clk_in);
endmodule : smai_core_properties

bind smai_core smai_core_properties smai_core_properties_inst (.core_clk_in, .sys_rst_in, .serial_clk_in,
    .conversion_clock_in, .chip_sel_n_in, .out_en_n_in, .serial_output_out, .serial_output_oe_out,
    .conversion_busy_out, .input_selector_out, .sample_en_out);

//--- sim/smai_host.sv
`timescale 1ns/1ns
module smai_host (
    // Clock
    input wire logic clk_in,
    // Link pins
    input wire logic do_in,
    output logic sclk_out,
    output logic cs_n_out,
    output logic di_out
);
    initial begin
        sclk_out = 1'b0;
        cs_n_out = 1'b1;
        di_out = 1'b0;
    end
    // One frame of nb periods, 5 low and 3 high core cycles each; bits read before each rise
    task automatic xfer(input logic [3:0] cmd, input int nb, input logic cs_hi, output logic [15:0] rx);
        rx = 16'h0000;
        @(negedge clk_in);
        cs_n_out = cs_hi;
        for (int i = 0; i < nb; i++) begin
            di_out = (i < 4) ? cmd[3-i] : ~di_out;
            repeat (5) @(negedge clk_in);
            rx = {rx[14:0], do_in};
            sclk_out = 1'b1;
            repeat (3) @(negedge clk_in);
            sclk_out = 1'b0;
        end
        di_out = ~di_out;
    endtask : xfer
endmodule : smai_host

//--- sim/serial_mux_adc_interface_test.sv
`timescale 1ns/1ns
module serial_mux_adc_interface_test;
    logic core_clk_in = 1'b0;
    logic sys_rst_in = 1'b1;
    logic conversion_clock_in = 1'b0;
    logic out_en_n_in = 1'b0;
    logic comparator_in;
    logic sclk, cs_n, di, so, so_oe, busy, samp;
    logic [2:0] sel;
    logic [9:0] approximation_register;
    logic [9:0] ana [8] = '{10'h3ff, 10'h001, 10'h2aa, 10'h155, 10'h200, 10'h1ff, 10'h000, 10'h37c};
    logic [9:0] pc = 10'h000;
    logic prj = 1'b0;
    int err_count = 0;
    int tests_run = 0;
    int cyc = 0;
    always #25 core_clk_in = ~core_clk_in;
    always #250 conversion_clock_in = ~conversion_clock_in;
    assign comparator_in = (ana[sel] >= approximation_register);
    smai_core smai_core_inst (.core_clk_in, .sys_rst_in, .serial_clk_in(sclk), .conversion_clock_in,
        .chip_sel_n_in(cs_n), .out_en_n_in, .serial_input_in(di), .serial_output_out(so),
        .serial_output_oe_out(so_oe), .conversion_busy_out(busy), .comparator_in, .input_selector_out(sel),
        .sample_en_out(samp), .approximation_register_out(approximation_register));
    smai_host smai_host_inst (.clk_in(core_clk_in), .do_in(so), .sclk_out(sclk), .cs_n_out(cs_n), .di_out(di));
    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_count++;
            $display("unexpected %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic conclude;
        $display("checks %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : conclude
    always @(posedge core_clk_in) begin
        cyc++;
        if (cyc == 20000) begin
            err_count++;
            conclude();
        end
    end
    // Frame sent with chip select high leaves everything idle
    task automatic t_cs_ignore;
        logic [15:0] rx;
        out_en_n_in = 1'b1;
        smai_host_inst.xfer(4'hb, 16, 1'b1, rx);
        repeat (40) @(negedge core_clk_in);
        chk("selector", {13'h0, sel}, 16'h0000);
        chk("busy", {15'h0, busy}, 16'h0000);
        chk("drive", {15'h0, so_oe}, 16'h0000);
        out_en_n_in = 1'b0;
    endtask : t_cs_ignore
    // Start a conversion on channel i[2:0], read the previous result unless i is 4, then wait for the load
    task automatic t_conv(input int i);
        logic [15:0] rx, ex;
        logic [2:0] ch;
        logic rj;
        int nb;
        ch = i[2:0];
        rj = i[0];
        nb = (i == 3) ? 10 : 16;
        out_en_n_in = (i == 4);
        smai_host_inst.xfer({ch, rj}, nb, 1'b0, rx);
        ex = prj ? {6'h00, pc} : ((nb == 16) ? {pc, 6'h00} : {6'h00, pc});
        if (i != 4) chk("result", rx, ex);
        chk("drive", {15'h0, so_oe}, {15'h0, 1'(i != 4)});
        chk("selector", {13'h0, sel}, {13'h0, ch});
        chk("busy", {15'h0, busy}, 16'h0001);
        repeat (600) if (busy) @(negedge core_clk_in);
        chk("busy", {15'h0, busy}, 16'h0000);
        if (i != 4) chk("first bit", {15'h0, so}, {15'h0, rj ? 1'b0 : ana[ch][9]});
        out_en_n_in = 1'b0;
        pc = ana[ch];
        prj = rj;
    endtask : t_conv
    initial begin
        repeat (8) @(negedge core_clk_in);
        sys_rst_in = 1'b0;
        repeat (4) @(negedge core_clk_in);
        t_cs_ignore();
        for (int i = 0; i <= 8; i++) begin
            t_conv(i);
        end
        conclude();
    end
endmodule : serial_mux_adc_interface_test
